// ### src/cassette_pkg.sv
// shared constants and types of the cassette positioning sequencer
package cassette_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // word offsets on the register bus
  localparam logic [ADDR_W-1:0] CONTROL_STATUS_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] BYTE_BUFFER_OFFSET = 12'h004;

  // control_status_reg field positions
  localparam int GO_BIT = 0;
  localparam int FN_LSB = 1;
  localparam int FN_MSB = 3;
  localparam int LAST_BYTE_BIT = 4;
  localparam int READY_BIT = 5;
  localparam int IRQ_ENABLE_BIT = 6;
  localparam int XFER_REQ_BIT = 7;
  localparam int UNIT_BIT = 8;
  localparam int OFF_LINE_BIT = 9;
  localparam int LONG_BLANK_BIT = 10;
  localparam int LATE_SERVICE_BIT = 11;
  localparam int WRITE_LOCK_BIT = 12;
  localparam int INTER_BLOCK_BIT = 13;
  localparam int TRANSPARENT_END_BIT = 14;
  localparam int ERROR_BIT = 15;

  localparam int BYTE_W = 8;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

  // function codes held in control_status_reg bits 3:1
  typedef enum logic [2:0] {
    FN_BLANK_GAP_WRITE = 3'h0,
    FN_WRITE = 3'h1,
    FN_READ = 3'h2,
    FN_REVERSE_FILE_SPACE = 3'h3,
    FN_REVERSE_BLOCK_SPACE = 3'h4,
    FN_FORWARD_FILE_SPACE = 3'h5,
    FN_FORWARD_BLOCK_SPACE = 3'h6,
    FN_REWIND = 3'h7
  } fn_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REJECT,
    ST_MOVE
  } state_t;

  // off-line / write-lock rejection delay
  localparam int CLK_PERIOD_NS = 100;
  localparam int REJECT_TIME_NS = 2000;
  localparam int REJECT_CYCLES_RAW = REJECT_TIME_NS / CLK_PERIOD_NS;
  localparam int REJECT_CYCLES = (REJECT_CYCLES_RAW < 1) ? 1 : REJECT_CYCLES_RAW;

endpackage

// ### src/settle_timer_if.sv
// start/done handshake between the sequencer and its delay timer
interface settle_timer_if;
  logic start;
  logic done;
  modport owner(output start, input done);
  modport timer(input start, output done);
endinterface

// ### src/settle_timer.sv
// one-shot delay timer: done pulses a fixed number of cycles after start
module settle_timer #(
  parameter int CYCLES = cassette_pkg::REJECT_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  settle_timer_if.timer t
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] count;
  } timer_state_t;

  localparam logic [15:0] LAST = 16'(CYCLES - 1);

  timer_state_t s_q;
  timer_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (t.start) begin
      s_d.busy = 1'b1;
      s_d.count = 16'h0000;
    end else if (s_q.busy) begin
      if (s_q.count == LAST) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.count = s_q.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign t.done = s_q.done;

endmodule

// ### src/cassette_positioning_sequencer.sv
// function sequencer of a two-drive cassette controller with an APB register slave
//
// The implementer's own choices: the register addresses and the APB slave port.
module cassette_positioning_sequencer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [cassette_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [cassette_pkg::DATA_W-1:0] pwdata_i,
  output logic [cassette_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [1:0] off_line_i,
  input wire logic [1:0] write_lock_i,
  input wire logic [1:0] tape_start_mark_i,
  input wire logic [1:0] tape_end_mark_i,
  input wire logic data_seen_i,
  input wire logic block_gap_i,
  input wire logic file_gap_i,
  input wire logic byte_strobe_i,
  input wire logic [cassette_pkg::BYTE_W-1:0] byte_in_i,
  input wire logic irq_ack_i,
  output logic drive_sel_o,
  output logic motion_fwd_o,
  output logic motion_rev_o,
  output logic rewind_o,
  output logic [cassette_pkg::BYTE_W-1:0] byte_out_o,
  output logic irq_o
);

  typedef struct packed {
    cassette_pkg::state_t state;
    cassette_pkg::fn_t fn;
    logic unit;
    logic ready;
    logic error;
    logic irq_enable;
    logic long_blank;
    logic inter_block;
    logic late_service;
    logic write_lock_err;
    logic xfer_req;
    logic seek_data;
    logic data_passed;
    logic cond_prev;
    logic irq;
    logic timer_start;
    logic fwd;
    logic rev;
    logic rew;
    logic pready;
    logic pslverr;
    logic [cassette_pkg::DATA_W-1:0] prdata;
    logic [cassette_pkg::BYTE_W-1:0] buffer;
  } seq_state_t;

  seq_state_t s_q;
  seq_state_t s_d;

  settle_timer_if tmr();

  settle_timer #(
    .CYCLES(cassette_pkg::REJECT_CYCLES)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .t(tmr.timer)
  );

  assign tmr.start = s_q.timer_start;

  function automatic logic is_forward(input cassette_pkg::fn_t f);
    return f inside {cassette_pkg::FN_BLANK_GAP_WRITE, cassette_pkg::FN_WRITE, cassette_pkg::FN_READ,
                     cassette_pkg::FN_FORWARD_FILE_SPACE, cassette_pkg::FN_FORWARD_BLOCK_SPACE};
  endfunction

  function automatic logic is_write(input cassette_pkg::fn_t f);
    return f inside {cassette_pkg::FN_BLANK_GAP_WRITE, cassette_pkg::FN_WRITE};
  endfunction

  logic sel_off_line;
  logic sel_at_start;
  logic sel_at_end;
  logic sel_locked;
  logic ready_visible;
  logic access_done;
  logic csr_hit;
  logic buf_hit;
  logic [cassette_pkg::DATA_W-1:0] csr_image;

  always_comb begin
    sel_off_line = off_line_i[s_q.unit];
    sel_at_start = tape_start_mark_i[s_q.unit];
    sel_at_end = tape_end_mark_i[s_q.unit];
    // write lock only shows while a writing function sits in the code field
    sel_locked = write_lock_i[s_q.unit] & is_write(s_q.fn);
    // a pending byte request keeps ready hidden
    ready_visible = s_q.ready & ~s_q.xfer_req;
    csr_hit = (paddr_i == cassette_pkg::CONTROL_STATUS_OFFSET);
    buf_hit = (paddr_i == cassette_pkg::BYTE_BUFFER_OFFSET);
    access_done = psel_i & penable_i & s_q.pready;
    csr_image = cassette_pkg::WORD_ZERO;
    csr_image[cassette_pkg::FN_MSB:cassette_pkg::FN_LSB] = s_q.fn;
    csr_image[cassette_pkg::READY_BIT] = ready_visible;
    csr_image[cassette_pkg::IRQ_ENABLE_BIT] = s_q.irq_enable;
    csr_image[cassette_pkg::XFER_REQ_BIT] = s_q.xfer_req;
    csr_image[cassette_pkg::UNIT_BIT] = s_q.unit;
    csr_image[cassette_pkg::OFF_LINE_BIT] = sel_off_line;
    csr_image[cassette_pkg::LONG_BLANK_BIT] = s_q.long_blank;
    csr_image[cassette_pkg::LATE_SERVICE_BIT] = s_q.late_service;
    csr_image[cassette_pkg::WRITE_LOCK_BIT] = sel_locked;
    csr_image[cassette_pkg::INTER_BLOCK_BIT] = s_q.inter_block;
    // live per selected drive: normal after rewind, a fault only with error
    csr_image[cassette_pkg::TRANSPARENT_END_BIT] = sel_at_start | sel_at_end;
    csr_image[cassette_pkg::ERROR_BIT] = s_q.error;
  end

  always_comb begin
    s_d = s_q;
    s_d.timer_start = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;

    // one wait state: pready rises in the second access cycle
    if (psel_i & penable_i & ~s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = ~(csr_hit | buf_hit);
      s_d.prdata = cassette_pkg::WORD_ZERO;
      if (!pwrite_i && csr_hit) begin
        s_d.prdata = csr_image;
      end else if (!pwrite_i && buf_hit) begin
        s_d.prdata[cassette_pkg::BYTE_W-1:0] = s_q.buffer;
      end
    end

    if (access_done && buf_hit) begin
      s_d.xfer_req = 1'b0;
      if (pwrite_i) begin
        s_d.buffer = pwdata_i[cassette_pkg::BYTE_W-1:0];
      end
    end

    if (access_done && csr_hit && pwrite_i) begin
      s_d.irq_enable = pwdata_i[cassette_pkg::IRQ_ENABLE_BIT];
      if (pwdata_i[cassette_pkg::LAST_BYTE_BIT]) begin
        s_d.xfer_req = 1'b0;
      end
      // code and unit are frozen while a function runs
      if (s_q.ready) begin
        s_d.fn = cassette_pkg::fn_t'(pwdata_i[cassette_pkg::FN_MSB:cassette_pkg::FN_LSB]);
        s_d.unit = pwdata_i[cassette_pkg::UNIT_BIT];
        if (pwdata_i[cassette_pkg::GO_BIT]) begin
          s_d.ready = 1'b0;
          s_d.error = 1'b0;
          if (off_line_i[pwdata_i[cassette_pkg::UNIT_BIT]] ||
              (write_lock_i[pwdata_i[cassette_pkg::UNIT_BIT]] &&
               is_write(cassette_pkg::fn_t'(pwdata_i[cassette_pkg::FN_MSB:cassette_pkg::FN_LSB])))) begin
            // not a successful start: latched flags other than error are left as they were
            s_d.state = cassette_pkg::ST_REJECT;
            s_d.timer_start = 1'b1;
          end else begin
            s_d.state = cassette_pkg::ST_MOVE;
            s_d.long_blank = 1'b0;
            s_d.inter_block = 1'b0;
            s_d.late_service = 1'b0;
            s_d.data_passed = 1'b0;
            // load point gap is skipped only when leaving the start mark
            s_d.seek_data = tape_start_mark_i[pwdata_i[cassette_pkg::UNIT_BIT]] &
                            ~is_write(cassette_pkg::fn_t'(pwdata_i[cassette_pkg::FN_MSB:cassette_pkg::FN_LSB]));
          end
        end
      end
    end

    // after the clears: a new byte request beats a service in the same cycle
    if (s_q.state == cassette_pkg::ST_MOVE && byte_strobe_i &&
        (s_q.fn == cassette_pkg::FN_READ || s_q.fn == cassette_pkg::FN_WRITE)) begin
      s_d.late_service = s_d.late_service | s_d.xfer_req;
      s_d.xfer_req = 1'b1;
      if (s_q.fn == cassette_pkg::FN_READ) begin
        s_d.buffer = byte_in_i;
      end
    end

    case (s_q.state)
      cassette_pkg::ST_IDLE: begin
        s_d.fwd = 1'b0;
        s_d.rev = 1'b0;
        s_d.rew = 1'b0;
      end
      cassette_pkg::ST_REJECT: begin
        if (tmr.done) begin
          s_d.ready = 1'b1;
          s_d.error = 1'b1;
          s_d.state = cassette_pkg::ST_IDLE;
        end
      end
      cassette_pkg::ST_MOVE: begin
        s_d.fwd = is_forward(s_q.fn);
        s_d.rev = (s_q.fn == cassette_pkg::FN_REVERSE_FILE_SPACE) ||
                  (s_q.fn == cassette_pkg::FN_REVERSE_BLOCK_SPACE);
        s_d.rew = (s_q.fn == cassette_pkg::FN_REWIND);
        if (s_q.fn == cassette_pkg::FN_REWIND) begin
          if (sel_at_start) begin
            s_d.ready = 1'b1;
            s_d.state = cassette_pkg::ST_IDLE;
          end
        end else if (s_d.rev) begin
          if (sel_at_start) begin
            s_d.ready = 1'b1;
            s_d.error = 1'b1;
            s_d.state = cassette_pkg::ST_IDLE;
          end else if (!s_q.data_passed) begin
            s_d.data_passed = data_seen_i;
          end else if (s_q.fn == cassette_pkg::FN_REVERSE_BLOCK_SPACE && (block_gap_i || file_gap_i)) begin
            s_d.ready = 1'b1;
            s_d.state = cassette_pkg::ST_IDLE;
          end else if (s_q.fn == cassette_pkg::FN_REVERSE_FILE_SPACE && file_gap_i) begin
            s_d.ready = 1'b1;
            s_d.long_blank = 1'b1;
            s_d.state = cassette_pkg::ST_IDLE;
          end
        end else if (sel_at_end && !s_q.seek_data) begin
          // start mark and end mark share the clear leader sensor
          s_d.ready = 1'b1;
          s_d.error = 1'b1;
          s_d.state = cassette_pkg::ST_IDLE;
        end else if (s_q.seek_data) begin
          s_d.seek_data = ~data_seen_i;
        end else begin
          // gaps are taken as they come, so a start in a gap reports that gap
          case (s_q.fn)
            cassette_pkg::FN_FORWARD_FILE_SPACE: begin
              if (file_gap_i) begin
                s_d.ready = 1'b1;
                s_d.long_blank = 1'b1;
                s_d.state = cassette_pkg::ST_IDLE;
              end
            end
            cassette_pkg::FN_FORWARD_BLOCK_SPACE, cassette_pkg::FN_READ: begin
              if (file_gap_i) begin
                s_d.ready = 1'b1;
                s_d.error = 1'b1;
                s_d.long_blank = 1'b1;
                s_d.state = cassette_pkg::ST_IDLE;
              end else if (block_gap_i) begin
                s_d.ready = 1'b1;
                s_d.inter_block = (s_q.fn == cassette_pkg::FN_FORWARD_BLOCK_SPACE);
                s_d.error = s_q.late_service;
                s_d.state = cassette_pkg::ST_IDLE;
              end
            end
            cassette_pkg::FN_WRITE: begin
              if (block_gap_i) begin
                s_d.ready = 1'b1;
                s_d.error = s_q.late_service;
                s_d.state = cassette_pkg::ST_IDLE;
              end
            end
            default: begin
              if (file_gap_i) begin
                s_d.ready = 1'b1;
                s_d.state = cassette_pkg::ST_IDLE;
              end
            end
          endcase
        end
        if (s_d.state == cassette_pkg::ST_IDLE) begin
          s_d.fwd = 1'b0;
          s_d.rev = 1'b0;
          s_d.rew = 1'b0;
        end
      end
      default: begin
        s_d.state = cassette_pkg::ST_IDLE;
        s_d.ready = 1'b1;
      end
    endcase

    // request on the rising edge, dropped on service or when the condition falls
    s_d.cond_prev = (ready_visible | s_q.xfer_req) & s_q.irq_enable;
    if (s_d.cond_prev && !s_q.cond_prev) begin
      s_d.irq = 1'b1;
    end else if (irq_ack_i || !s_d.cond_prev) begin
      s_d.irq = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.state <= cassette_pkg::ST_IDLE;
      s_q.fn <= cassette_pkg::FN_BLANK_GAP_WRITE;
      s_q.ready <= 1'b1;
      s_q.buffer <= cassette_pkg::BYTE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign drive_sel_o = s_q.unit;
  assign motion_fwd_o = s_q.fwd;
  assign motion_rev_o = s_q.rev;
  assign rewind_o = s_q.rew;
  assign byte_out_o = s_q.buffer;
  assign irq_o = s_q.irq;

endmodule

// ### testbench/cassette_transport_model.sv
// behavioural two-drive cassette transport playing a short event script while tape moves
module cassette_transport_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic drive_sel_i,
  input wire logic motion_fwd_i,
  input wire logic motion_rev_i,
  input wire logic rewind_i,
  input wire logic load_i,
  input wire logic [1:0] start_set_i,
  input wire logic [1:0] end_set_i,
  input wire logic [15:0] script_i,
  output logic [1:0] tape_start_mark_o,
  output logic [1:0] tape_end_mark_o,
  output logic data_seen_o,
  output logic block_gap_o,
  output logic file_gap_o,
  output logic [2:0] events_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] pace_q;
  logic [3:0] ev;
  // codes: 1 data, 2 block gap, 3 file gap, 4 clear leader reached
  assign ev = script_i[4*events_o[1:0] +: 4];
  // one event per 16 moving cycles leaves room for register traffic between events
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pace_q <= 4'h0;
      events_o <= 3'h0;
      tape_start_mark_o <= 2'h0;
      tape_end_mark_o <= 2'h0;
      data_seen_o <= 1'b0;
      block_gap_o <= 1'b0;
      file_gap_o <= 1'b0;
    end else begin
      data_seen_o <= 1'b0;
      block_gap_o <= 1'b0;
      file_gap_o <= 1'b0;
      if (load_i) begin
        pace_q <= 4'h0;
        events_o <= 3'h0;
        tape_start_mark_o <= start_set_i;
        tape_end_mark_o <= end_set_i;
      end else if ((motion_fwd_i || motion_rev_i || rewind_i) && events_o < 3'h4) begin
        pace_q <= pace_q + 4'h1;
        // forward motion leaves the leader in its second moving cycle (pace 1), before any script event
        if (motion_fwd_i && pace_q == 4'h1) begin
          tape_start_mark_o[drive_sel_i] <= 1'b0;
        end
        if (pace_q == 4'hF) begin
          events_o <= events_o + 3'h1;
          data_seen_o <= (ev == 4'h1);
          block_gap_o <= (ev == 4'h2);
          file_gap_o <= (ev == 4'h3);
          if (ev == 4'h4 && motion_fwd_i) begin
            tape_end_mark_o[drive_sel_i] <= 1'b1;
          end
          if (ev == 4'h4 && !motion_fwd_i) begin
            tape_start_mark_o[drive_sel_i] <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ### testbench/cassette_positioning_sequencer_asserts.sv
// port-level assertions of the cassette positioning sequencer
module cassette_positioning_sequencer_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [cassette_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [cassette_pkg::DATA_W-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [1:0] tape_start_mark_i,
  input wire logic [1:0] tape_end_mark_i,
  input wire logic irq_ack_i,
  input wire logic drive_sel_o,
  input wire logic motion_fwd_o,
  input wire logic motion_rev_o,
  input wire logic rewind_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wait_state_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready missing after first access cycle");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("pready without access cycle");
  unmapped_err_a: assert property (pready_o |-> pslverr_o == (paddr_i != cassette_pkg::CONTROL_STATUS_OFFSET
    && paddr_i != cassette_pkg::BYTE_BUFFER_OFFSET))
    else $error("slave error does not match address decode");
  err_data_a: assert property (pready_o && pslverr_o |-> prdata_o == cassette_pkg::WORD_ZERO)
    else $error("read data not zero on slave error");
  one_dir_a: assert property (!(motion_fwd_o && motion_rev_o))
    else $error("forward and reverse motion together");
  unit_hold_a: assert property ($past(motion_fwd_o || motion_rev_o || rewind_o)
    && (motion_fwd_o || motion_rev_o || rewind_o) |-> $stable(drive_sel_o))
    else $error("drive select changed during motion");
  rewind_stop_a: assert property (rewind_o && tape_start_mark_i[drive_sel_o] |-> ##[1:4] !rewind_o)
    else $error("rewind continues past tape start");
  rev_stop_a: assert property (motion_rev_o && tape_start_mark_i[drive_sel_o] |-> ##[1:4] !motion_rev_o)
    else $error("reverse motion continues at tape start");
  fwd_stop_a: assert property (motion_fwd_o && tape_end_mark_i[drive_sel_o] |-> ##[1:4] !motion_fwd_o)
    else $error("forward motion continues at tape end");
  ack_clear_a: assert property (irq_ack_i |=> !irq_o)
    else $error("interrupt request kept after acknowledge");
endmodule

bind cassette_positioning_sequencer cassette_positioning_sequencer_asserts i_cassette_positioning_sequencer_asserts (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .tape_start_mark_i(tape_start_mark_i),
  .tape_end_mark_i(tape_end_mark_i), .irq_ack_i(irq_ack_i), .drive_sel_o(drive_sel_o),
  .motion_fwd_o(motion_fwd_o), .motion_rev_o(motion_rev_o), .rewind_o(rewind_o), .irq_o(irq_o));

// ### testbench/cassette_positioning_sequencer_tb.sv
// self-checking bench: tape functions issued over the register bus against a transport model
module cassette_positioning_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic unit; logic [2:0] fn; logic [1:0] st; logic [1:0] en; logic [1:0] ol; logic [1:0] wl;
    logic [15:0] scr; logic [15:0] exp; logic [2:0] idx;
  } case_t;
  logic sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, load, irq_ack_i, irq_o;
  logic drive_sel_o, motion_fwd_o, motion_rev_o, rewind_o, data_seen_i, block_gap_i, file_gap_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic [1:0] off_line_i, write_lock_i, start_set, end_set, tape_start_mark_i, tape_end_mark_i;
  logic [15:0] script;
  logic [7:0] byte_out_o;
  logic [2:0] events;
  logic e;
  int err_count, checks_done, cyc;

  cassette_positioning_sequencer i_cassette_positioning_sequencer (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .off_line_i(off_line_i),
    .write_lock_i(write_lock_i), .tape_start_mark_i(tape_start_mark_i), .tape_end_mark_i(tape_end_mark_i),
    .data_seen_i(data_seen_i), .block_gap_i(block_gap_i), .file_gap_i(file_gap_i), .byte_strobe_i(data_seen_i),
    .byte_in_i(8'hA5), .irq_ack_i(irq_ack_i), .drive_sel_o(drive_sel_o), .motion_fwd_o(motion_fwd_o),
    .motion_rev_o(motion_rev_o), .rewind_o(rewind_o), .byte_out_o(byte_out_o), .irq_o(irq_o));
  cassette_transport_model i_cassette_transport_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .drive_sel_i(drive_sel_o), .motion_fwd_i(motion_fwd_o), .motion_rev_i(motion_rev_o), .rewind_i(rewind_o),
    .load_i(load), .start_set_i(start_set), .end_set_i(end_set), .script_i(script),
    .tape_start_mark_o(tape_start_mark_i), .tape_end_mark_o(tape_end_mark_i), .data_seen_o(data_seen_i),
    .block_gap_o(block_gap_i), .file_gap_o(file_gap_i), .events_o(events));

  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc <= cyc + 1;

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one transfer with one wait state expected, but the answer is awaited, not assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic er);
    int n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
    if (n >= 20) check("pready", 32'h0, 32'h1);
  endtask

  // idx: events the transport played before completion or a byte request; 0 means refused, 7 means not counted
  task automatic run_row(input case_t c);
    int n, t;
    off_line_i <= c.ol;
    write_lock_i <= c.wl;
    start_set <= c.st;
    end_set <= c.en;
    script <= c.scr;
    load <= 1'b1;
    @(posedge sys_clk_i);
    load <= 1'b0;
    apb(1'b1, 12'h000, {23'h0, c.unit, 4'h0, c.fn, 1'b1}, q, e);
    t = cyc;
    apb(1'b0, 12'h000, 32'h0, q, e);
    if (c.idx != 3'h7) check("running", q & (c.idx == 3'h0 ? 32'h20 : 32'h2420), 32'h0);
    if (c.idx != 3'h0 && c.idx != 3'h7) apb(1'b1, 12'h000, {23'h0, ~c.unit, 8'h0F}, q, e);
    n = 0;
    do begin
      apb(1'b0, 12'h000, 32'h0, q, e);
      n++;
    end while (q[5] !== 1'b1 && q[7] !== 1'b1 && n < 100);
    check("status", q & 32'hF6A0, {16'h0, c.exp});
    check("unit", {31'h0, drive_sel_o}, {31'h0, c.unit});
    if (c.idx != 3'h7) check("events", {29'h0, events}, {29'h0, c.idx});
    if (c.idx == 3'h0) check("refusal time", {31'h0, (cyc - t >= 18 && cyc - t <= 27)}, 32'h1);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk_i);
    err_count++;
    complete_run();
  end

  initial begin
    sys_clk_i = 1'b0;
    rst_i = 1'b1;
    {psel_i, penable_i, pwrite_i, load, irq_ack_i} = 5'h00;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    {off_line_i, write_lock_i, start_set, end_set} = 8'h00;
    script = 16'h0000;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    apb(1'b0, 12'h000, 32'h0, q, e);
    check("reset status", q, 32'h00000020);
    apb(1'b0, 12'h004, 32'h0, q, e);
    check("reset buffer", q, 32'h00000000);
    apb(1'b0, 12'h008, 32'h0, q, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    run_row('{1'b0, 3'h4, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0212, 16'h0020, 3'h3});
    run_row('{1'b0, 3'h4, 2'h1, 2'h0, 2'h0, 2'h0, 16'h0000, 16'hC020, 3'h7});
    run_row('{1'b0, 3'h4, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0004, 16'hC020, 3'h1});
    run_row('{1'b0, 3'h5, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0003, 16'h0420, 3'h1});
    run_row('{1'b0, 3'h5, 2'h1, 2'h0, 2'h0, 2'h0, 16'h0313, 16'h0420, 3'h3});
    run_row('{1'b1, 3'h5, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0004, 16'hC020, 3'h1});
    run_row('{1'b0, 3'h6, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0002, 16'h2020, 3'h1});
    run_row('{1'b1, 3'h6, 2'h2, 2'h0, 2'h0, 2'h0, 16'h0212, 16'h2020, 3'h3});
    run_row('{1'b0, 3'h6, 2'h0, 2'h1, 2'h0, 2'h0, 16'h0000, 16'hC020, 3'h7});
    run_row('{1'b0, 3'h6, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0003, 16'h8420, 3'h1});
    run_row('{1'b0, 3'h2, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0003, 16'h8420, 3'h1});
    run_row('{1'b1, 3'h3, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0312, 16'h0420, 3'h3});
    run_row('{1'b1, 3'h7, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0400, 16'h4020, 3'h3});
    // writes only follow a rewind, never repeat after reverse spacing, later tape never read
    run_row('{1'b1, 3'h0, 2'h0, 2'h0, 2'h0, 2'h2, 16'h0000, 16'h9020, 3'h0});
    run_row('{1'b0, 3'h1, 2'h0, 2'h0, 2'h1, 2'h0, 16'h0000, 16'h8220, 3'h0});
    // read takes one byte, then completes in the block gap behind the pending request
    run_row('{1'b0, 3'h2, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0021, 16'h0080, 3'h1});
    apb(1'b0, 12'h004, 32'h0, q, e);
    check("buffer read", q, 32'h000000A5);
    check("byte out", {24'h0, byte_out_o}, 32'h000000A5);
    repeat (40) @(posedge sys_clk_i);
    apb(1'b0, 12'h000, 32'h0, q, e);
    check("ready after service", q & 32'h0000F6A0, 32'h00000020);
    apb(1'b1, 12'h000, 32'h00000040, q, e);
    @(posedge sys_clk_i);
    check("irq raised", {31'h0, irq_o}, 32'h1);
    irq_ack_i <= 1'b1;
    @(posedge sys_clk_i);
    irq_ack_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    check("irq served", {31'h0, irq_o}, 32'h0);
    complete_run();
  end
endmodule
